/* shared/sac_pkg.sv */
// Shared constants and state types for the converter link and its two ends
package sac_pkg;

	localparam int DATA_W = 16;
	localparam int CNT_W  = 5;
	localparam int CONV_W = 8;
	localparam int WAIT_W = 8;

	// Clock periods of both domains
	localparam int LINK_PERIOD_NS = 80;
	localparam int SYS_PERIOD_NS  = 25;

	// Conversion window of the internal oscillator
	localparam int T_CONV_MIN_NS = 2000;
	localparam int T_CONV_MAX_NS = 4000;
	localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / LINK_PERIOD_NS;
	localparam int CONV_DEF_CYC  = (CONV_MIN_CYC + CONV_MAX_CYC) / 2;

	// Host side timing
	localparam int T_START_PULSE_NS = 800;
	localparam int START_PULSE_CYC  = (T_START_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int T_SYNC_MARGIN_NS = 400;
	localparam int HOST_WAIT_CYC    =
		(T_CONV_MAX_NS + T_SYNC_MARGIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int T_SCLK_HALF_NS   = 400;
	localparam int SCLK_HALF_CYC    = (T_SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// Falling serial clock edges that end a readout
	localparam logic [CNT_W-1:0] EDGES_NO_BUSY = 5'h10;
	localparam logic [CNT_W-1:0] EDGES_BUSY    = 5'h11;

	// Values after reset
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [CNT_W-1:0]  EDGE_RST = 5'h00;
	localparam logic [CONV_W-1:0] CONV_RST = 8'h00;
	localparam logic [WAIT_W-1:0] WAIT_RST = 8'h00;

	typedef enum {DEV_ACQ, DEV_CONV, DEV_READY, DEV_SHIFT} sac_dev_state_e;
	typedef enum {HST_IDLE, HST_CONV, HST_IRQ, HST_LOW, HST_HIGH, HST_DONE, HST_END}
		sac_hst_state_e;

endpackage

/* shared/sac_link_if.sv */
// Pin-level link between the converter and its serial host
`timescale 1ns/10ps
interface sac_link_if;
	logic convert_start_pin;
	logic serial_in_pin;
	logic sclk;
	logic serial_out_o;
	logic serial_out_oe_n;
	logic serial_out_line;

	// Pull-up holds the line high while the converter lets go
	assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out_o;

	modport dev
	(
		input  convert_start_pin,
		input  serial_in_pin,
		input  sclk,
		output serial_out_o,
		output serial_out_oe_n
	);

	modport hst
	(
		output convert_start_pin,
		output serial_in_pin,
		output sclk,
		input  serial_out_line
	);
endinterface

/* logic/sac_adc_dev.sv */
// Converter end: mode select, timed conversion and serial readout
`timescale 1ns/10ps

// Notes on behaviour
// - Input high at start edge selects select-mode
// - Input low at start edge selects chain mode (not built: converter stays off the line)
// - Busy option sends one bit before data
// - Conversion timed internally; serial clock only reads
// - Readout only after conversion, during acquisition
// - Result shifted out as two's complement
// - Start edge releases output, samples, converts
// - Conversion ignores start pin once running
// - Host keeps start high across conversion window
// - Start high at end means no busy
// - Start falling edge drives MSB, then clock
// - Release after sixteenth fall or start high
// - Host holds start low across conversion window
// - Busy low at end, then data MSB first
// - Release after seventeenth fall or start high
// - Bit stays valid over both clock edges
// - Four-wire host keeps start high throughout
// - Four-wire host keeps input high across window
// - Input falling edge drives MSB, then clock
// - Release after sixteenth fall or input high
// - Next device selected only after release
// - Start and input never low together
module sac_adc_dev
	import sac_pkg::*;
#(
	parameter int CONV_CYC = CONV_DEF_CYC
)
(
	input  wire logic              link_clk,
	input  wire logic              link_rst,
	input  wire logic [DATA_W-1:0] sample_in,
	sac_link_if.dev                link,
	output logic                   converting,
	output logic                   reading,
	output logic                   cs_mode,
	output logic                   busy_option,
	output logic [DATA_W-1:0]      last_result
);

	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic fall(input logic cur, input logic prev);
		return ~cur & prev;
	endfunction

	sac_dev_state_e    state_ff;
	sac_dev_state_e    nxt_state;
	logic [1:0]        cv_sync_ff;
	logic [1:0]        di_sync_ff;
	logic [1:0]        sk_sync_ff;
	logic              cv_prev_ff;
	logic              di_prev_ff;
	logic              sk_prev_ff;
	logic [CONV_W-1:0] cnt_ff;
	logic [CONV_W-1:0] nxt_cnt;
	logic [CNT_W-1:0]  edge_ff;
	logic [CNT_W-1:0]  nxt_edge;
	logic [DATA_W-1:0] smp_sync0_ff;
	logic [DATA_W-1:0] smp_sync1_ff;
	logic [DATA_W-1:0] sample_ff;
	logic [DATA_W-1:0] nxt_sample;
	logic [DATA_W-1:0] shreg_ff;
	logic [DATA_W-1:0] nxt_shreg;
	logic [DATA_W-1:0] result_ff;
	logic [DATA_W-1:0] nxt_result;
	logic              dout_ff;
	logic              nxt_dout;
	logic              oe_n_ff;
	logic              nxt_oe_n;
	logic              cs_ff;
	logic              nxt_cs;
	logic              busy_ff;
	logic              nxt_busy;
	logic              conv_flag_ff;
	logic              read_flag_ff;

	// Synchronised pins; only the second stage feeds logic
	wire               cv_s       = cv_sync_ff[1];
	wire               di_s       = di_sync_ff[1];
	wire               sk_s       = sk_sync_ff[1];
	wire               sel_s      = cv_s & di_s;
	wire               sel_prev   = cv_prev_ff & di_prev_ff;
	wire               cv_rise    = rise(cv_s, cv_prev_ff);
	wire               sel_fall   = fall(sel_s, sel_prev);
	wire               sel_rise   = rise(sel_s, sel_prev);
	wire               sk_fall    = fall(sk_s, sk_prev_ff);
	wire [CONV_W-1:0]  conv_last  = CONV_W'(CONV_CYC - 1);
	wire [CNT_W-1:0]   edge_next  = edge_ff + 5'h01;
	wire [CNT_W-1:0]   edge_total = busy_ff ? EDGES_BUSY : EDGES_NO_BUSY;
	wire [DATA_W-1:0]  shreg_shl  = {shreg_ff[DATA_W-2:0], 1'b0};

	always_comb
	begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_edge   = edge_ff;
		nxt_sample = sample_ff;
		nxt_shreg  = shreg_ff;
		nxt_result = result_ff;
		nxt_dout   = dout_ff;
		nxt_oe_n   = oe_n_ff;
		nxt_cs     = cs_ff;
		nxt_busy   = busy_ff;
		case (state_ff)
			DEV_CONV:
			begin
				// Runs on the link clock alone, whatever the pins do
				nxt_cnt = cnt_ff + 8'h01;
				if (cnt_ff == conv_last)
				begin
					nxt_shreg  = sample_ff;
					nxt_result = sample_ff;
					if (!cs_ff)
					begin
						// Chain mode is not built: stay off the line
						nxt_state = DEV_ACQ;
					end
					else if (sel_s)
					begin
						nxt_state = DEV_READY;
					end
					else
					begin
						nxt_state = DEV_SHIFT;
						nxt_oe_n  = 1'b0;
						nxt_dout  = 1'b0;
						nxt_busy  = 1'b1;
						nxt_edge  = EDGE_RST;
					end
				end
			end
			DEV_READY:
			begin
				if (sel_fall)
				begin
					nxt_state = DEV_SHIFT;
					nxt_oe_n  = 1'b0;
					nxt_dout  = shreg_ff[DATA_W-1];
					nxt_shreg = shreg_shl;
					nxt_busy  = 1'b0;
					nxt_edge  = EDGE_RST;
				end
			end
			DEV_SHIFT:
			begin
				if (sel_s || sel_rise)
				begin
					nxt_state = DEV_ACQ;
					nxt_oe_n  = 1'b1;
					nxt_dout  = 1'b1;
				end
				else if (sk_fall)
				begin
					nxt_edge = edge_next;
					if (edge_next == edge_total)
					begin
						nxt_state = DEV_ACQ;
						nxt_oe_n  = 1'b1;
						nxt_dout  = 1'b1;
					end
					else
					begin
						// Changes only after a fall, so it holds over the rise
						nxt_dout  = shreg_ff[DATA_W-1];
						nxt_shreg = shreg_shl;
					end
				end
			end
			default:
			begin
			end
		endcase
		// A start edge during conversion is ignored
		if (cv_rise && state_ff != DEV_CONV)
		begin
			nxt_cs     = di_s;
			nxt_sample = smp_sync1_ff;
			nxt_oe_n   = 1'b1;
			nxt_dout   = 1'b1;
			nxt_cnt    = CONV_RST;
			nxt_busy   = 1'b0;
			nxt_state  = DEV_CONV;
		end
	end

	always_ff @(posedge link_clk)
	begin
		cv_sync_ff <= {cv_sync_ff[0], link.convert_start_pin};
		di_sync_ff <= {di_sync_ff[0], link.serial_in_pin};
		sk_sync_ff <= {sk_sync_ff[0], link.sclk};
		// Word is held long before the start edge clears its own synchroniser
		smp_sync0_ff <= sample_in;
		smp_sync1_ff <= smp_sync0_ff;
		if (link_rst)
		begin
			cv_prev_ff   <= 1'b0;
			di_prev_ff   <= 1'b1;
			sk_prev_ff   <= 1'b0;
			state_ff     <= DEV_ACQ;
			cnt_ff       <= CONV_RST;
			edge_ff      <= EDGE_RST;
			sample_ff    <= DATA_RST;
			shreg_ff     <= DATA_RST;
			result_ff    <= DATA_RST;
			dout_ff      <= 1'b1;
			oe_n_ff      <= 1'b1;
			cs_ff        <= 1'b0;
			busy_ff      <= 1'b0;
			conv_flag_ff <= 1'b0;
			read_flag_ff <= 1'b0;
		end
		else
		begin
			cv_prev_ff   <= cv_s;
			di_prev_ff   <= di_s;
			sk_prev_ff   <= sk_s;
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			edge_ff      <= nxt_edge;
			sample_ff    <= nxt_sample;
			shreg_ff     <= nxt_shreg;
			result_ff    <= nxt_result;
			dout_ff      <= nxt_dout;
			oe_n_ff      <= nxt_oe_n;
			cs_ff        <= nxt_cs;
			busy_ff      <= nxt_busy;
			conv_flag_ff <= (nxt_state == DEV_CONV);
			read_flag_ff <= (nxt_state == DEV_SHIFT);
		end
	end

	assign link.serial_out_o    = dout_ff;
	assign link.serial_out_oe_n = oe_n_ff;
	assign converting           = conv_flag_ff;
	assign reading              = read_flag_ff;
	assign cs_mode              = cs_ff;
	assign busy_option          = busy_ff;
	assign last_result          = result_ff;

endmodule // sac_adc_dev

/* logic/sac_adc_host.sv */
// Host end: start pulse, serial clock divider and result capture
`timescale 1ns/10ps
module sac_adc_host
	import sac_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         start,
	input  wire logic         busy_sel,
	input  wire logic         four_wire,
	sac_link_if.hst           link,
	output logic [DATA_W-1:0] data_out,
	output logic              data_valid,
	output logic              host_busy
);

	sac_hst_state_e    state_ff;
	sac_hst_state_e    nxt_state;
	logic [1:0]        do_sync_ff;
	logic [WAIT_W-1:0] cnt_ff;
	logic [WAIT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0]  bit_ff;
	logic [CNT_W-1:0]  nxt_bit;
	logic [DATA_W-1:0] rx_ff;
	logic [DATA_W-1:0] nxt_rx;
	logic [DATA_W-1:0] data_ff;
	logic [DATA_W-1:0] nxt_data;
	logic              valid_ff;
	logic              nxt_valid;
	logic              convert_start_pin_ff;
	logic              nxt_convert_start_pin;
	logic              din_ff;
	logic              nxt_din;
	logic              sclk_ff;
	logic              nxt_sclk;
	logic              busy_ff;
	logic              nxt_busy;
	logic              four_ff;
	logic              nxt_four;
	logic              act_ff;

	wire               do_s       = do_sync_ff[1];
	wire [WAIT_W-1:0]  cnt_inc    = cnt_ff + 8'h01;
	wire [CNT_W-1:0]   bit_inc    = bit_ff + 5'h01;
	wire [WAIT_W-1:0]  pulse_last = WAIT_W'(START_PULSE_CYC - 1);
	wire [WAIT_W-1:0]  wait_last  = WAIT_W'(HOST_WAIT_CYC - 1);
	wire [WAIT_W-1:0]  half_last  = WAIT_W'(SCLK_HALF_CYC - 1);
	wire [CNT_W-1:0]   bit_total  = busy_ff ? EDGES_BUSY : EDGES_NO_BUSY;

	always_comb
	begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_bit    = bit_ff;
		nxt_rx     = rx_ff;
		nxt_data   = data_ff;
		nxt_valid  = 1'b0;
		nxt_convert_start_pin = convert_start_pin_ff;
		nxt_din    = din_ff;
		nxt_sclk   = sclk_ff;
		nxt_busy   = busy_ff;
		nxt_four   = four_ff;
		case (state_ff)
			HST_IDLE:
			begin
				if (start)
				begin
					// Four-wire is built without the busy bit only
					nxt_four   = four_wire;
					nxt_busy   = busy_sel & ~four_wire;
					nxt_din    = 1'b1;
					nxt_convert_start_pin = 1'b1;
					nxt_cnt    = WAIT_RST;
					nxt_state  = HST_CONV;
				end
			end
			HST_CONV:
			begin
				nxt_cnt = cnt_inc;
				if (busy_ff && cnt_ff == pulse_last)
				begin
					nxt_convert_start_pin = 1'b0;
				end
				if (cnt_ff == wait_last)
				begin
					nxt_cnt = WAIT_RST;
					nxt_bit = EDGE_RST;
					if (busy_ff)
					begin
						nxt_state = HST_IRQ;
					end
					else
					begin
						// Select only after the longest conversion
						nxt_state = HST_LOW;
						if (four_ff)
						begin
							nxt_din = 1'b0;
						end
						else
						begin
							nxt_convert_start_pin = 1'b0;
						end
					end
				end
			end
			HST_IRQ:
			begin
				if (!do_s)
				begin
					nxt_state = HST_LOW;
					nxt_cnt   = WAIT_RST;
				end
			end
			HST_LOW:
			begin
				nxt_cnt = cnt_inc;
				if (cnt_ff == half_last)
				begin
					// Capture just before the rise, mid-bit
					nxt_rx    = {rx_ff[DATA_W-2:0], do_s};
					nxt_sclk  = 1'b1;
					nxt_cnt   = WAIT_RST;
					nxt_state = HST_HIGH;
				end
			end
			HST_HIGH:
			begin
				nxt_cnt = cnt_inc;
				if (cnt_ff == half_last)
				begin
					nxt_sclk  = 1'b0;
					nxt_cnt   = WAIT_RST;
					nxt_bit   = bit_inc;
					nxt_state = (bit_inc == bit_total) ? HST_DONE : HST_LOW;
				end
			end
			HST_DONE:
			begin
				// Four-wire deselect; raising select first keeps pins apart
				nxt_din   = 1'b1;
				nxt_data  = rx_ff;
				nxt_valid = 1'b1;
				nxt_state = HST_END;
			end
			HST_END:
			begin
				nxt_convert_start_pin = 1'b0;
				nxt_state  = HST_IDLE;
			end
			default:
			begin
				nxt_state = HST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		do_sync_ff <= {do_sync_ff[0], link.serial_out_line};
		if (srst)
		begin
			state_ff  <= HST_IDLE;
			cnt_ff    <= WAIT_RST;
			bit_ff    <= EDGE_RST;
			rx_ff     <= DATA_RST;
			data_ff   <= DATA_RST;
			valid_ff  <= 1'b0;
			convert_start_pin_ff <= 1'b0;
			din_ff    <= 1'b1;
			sclk_ff   <= 1'b0;
			busy_ff   <= 1'b0;
			four_ff   <= 1'b0;
			act_ff    <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			bit_ff    <= nxt_bit;
			rx_ff     <= nxt_rx;
			data_ff   <= nxt_data;
			valid_ff  <= nxt_valid;
			convert_start_pin_ff <= nxt_convert_start_pin;
			din_ff    <= nxt_din;
			sclk_ff   <= nxt_sclk;
			busy_ff   <= nxt_busy;
			four_ff   <= nxt_four;
			act_ff    <= (nxt_state != HST_IDLE);
		end
	end

	assign link.convert_start_pin = convert_start_pin_ff;
	assign link.serial_in_pin     = din_ff;
	assign link.sclk              = sclk_ff;
	assign data_out               = data_ff;
	assign data_valid             = valid_ff;
	assign host_busy              = act_ff;

endmodule // sac_adc_host

/* bench/sac_link_props.sv */
// Concurrent checks on the converter link pins
`timescale 1ns/10ps
module sac_link_props
	import sac_pkg::*;
(
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic convert_start_pin,
	input wire logic serial_in_pin,
	input wire logic sclk,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n,
	input wire logic serial_out_line
);
	logic       sclk_ff;
	logic       oe_n_ff;
	logic       busy_rd_ff;
	logic [4:0] falls_ff;
	logic [7:0] since_ff;
	logic [7:0] low_ff;
	wire        sclk_fall = sclk_ff & ~sclk;
	wire        sel       = convert_start_pin & serial_in_pin;
	wire        long_low  = (low_ff > 8'h08);
	wire  [4:0] lim       = busy_rd_ff ? EDGES_BUSY : EDGES_NO_BUSY;

	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (link_rst);

	// Pins are sampled raw; serial clock half period spans five link cycles
	always_ff @(posedge link_clk)
	begin
		sclk_ff <= link_rst ? 1'b0 : sclk;
		oe_n_ff <= link_rst ? 1'b1 : serial_out_oe_n;
	end

	always_ff @(posedge link_clk)
	begin
		if (link_rst || serial_out_oe_n)
			falls_ff <= 5'h00;
		else if (sclk_fall)
			falls_ff <= falls_ff + 5'h01;
	end

	// Busy readout: start pin already low well before the output came on
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
			busy_rd_ff <= 1'b0;
		else if (oe_n_ff && !serial_out_oe_n)
			busy_rd_ff <= long_low;
	end

	always_ff @(posedge link_clk)
	begin
		if (link_rst || $rose(convert_start_pin))
			since_ff <= 8'h00;
		else if (since_ff != 8'hff)
			since_ff <= since_ff + 8'h01;
	end

	always_ff @(posedge link_clk)
	begin
		if (link_rst || convert_start_pin)
			low_ff <= 8'h00;
		else if (low_ff != 8'hff)
			low_ff <= low_ff + 8'h01;
	end

	sequence s_start;
		$rose(convert_start_pin);
	endsequence
	sequence s_quiet;
		serial_out_oe_n [*8];
	endsequence

	a_start_quiet: assert property (s_start |-> ##6 s_quiet)
		else $error("output driven early in conversion");
	a_conv_min: assert property ($fell(serial_out_oe_n) |-> int'(since_ff) >= CONV_MIN_CYC)
		else $error("output enabled before minimum conversion");
	a_busy_prompt: assert property ($fell(serial_out_oe_n) && long_low
		|-> int'(since_ff) <= CONV_MAX_CYC + 6 && !serial_out_o)
		else $error("busy bit late or high");
	a_enable_select: assert property ($fell(serial_out_oe_n) |-> !sel)
		else $error("output enabled while deselected");
	a_bit_stable: assert property (!serial_out_oe_n && !$past(serial_out_oe_n)
		&& $changed(serial_out_o) |-> !$past(sclk, 2))
		else $error("data changed outside clock low phase");
	a_count_limit: assert property (!serial_out_oe_n |-> falls_ff <= lim)
		else $error("output driven past final clock edge");
	a_release_count: assert property (!serial_out_oe_n && falls_ff == lim
		|-> ##[0:6] serial_out_oe_n)
		else $error("no release after final clock edge");
	a_release_select: assert property ($rose(sel) |-> ##[0:6] serial_out_oe_n)
		else $error("no release on deselect");
endmodule // sac_link_props

/* bench/tb_top.sv */
// Self-checking bench: host and converter joined over the link
`timescale 1ns/10ps
`define CHK(a, b) \
	begin \
		compares++; \
		if ((a) !== (b)) \
		begin \
			mismatches++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
		end \
	end
module tb_top
	import sac_pkg::*;
;
	logic              clk_sys;
	logic              srst;
	logic              link_clk;
	logic              link_rst;
	logic              start;
	logic              busy_sel;
	logic              four_wire;
	logic [DATA_W-1:0] sample_in;
	logic [DATA_W-1:0] data_out;
	logic              data_valid;
	logic              host_busy;
	logic              converting;
	logic              reading;
	logic              cs_mode;
	logic              busy_option;
	logic [DATA_W-1:0] last_result;
	logic              first_bit;
	int                mismatches = 0;
	int                compares = 0;
	int                cycles = 0;
	int                vld_cnt = 0;

	sac_link_if u_sac_link_if ();

	sac_adc_dev u_sac_adc_dev (.link_clk(link_clk), .link_rst(link_rst),
		.sample_in(sample_in), .link(u_sac_link_if), .converting(converting),
		.reading(reading), .cs_mode(cs_mode), .busy_option(busy_option),
		.last_result(last_result));

	sac_adc_host u_sac_adc_host (.clk_sys(clk_sys), .srst(srst), .start(start),
		.busy_sel(busy_sel), .four_wire(four_wire), .link(u_sac_link_if),
		.data_out(data_out), .data_valid(data_valid), .host_busy(host_busy));

	sac_link_props u_sac_link_props (.link_clk(link_clk), .link_rst(link_rst),
		.convert_start_pin(u_sac_link_if.convert_start_pin),
		.serial_in_pin(u_sac_link_if.serial_in_pin), .sclk(u_sac_link_if.sclk),
		.serial_out_o(u_sac_link_if.serial_out_o),
		.serial_out_oe_n(u_sac_link_if.serial_out_oe_n),
		.serial_out_line(u_sac_link_if.serial_out_line));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Offset start keeps the two clocks out of phase
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #40 link_clk = ~link_clk;
	end

	task automatic conclude();
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cycles++;
		if (data_valid === 1'b1)
			vld_cnt++;
		if (cycles == 20000)
		begin
			mismatches++;
			conclude();
		end
	end

	// Both selects low together would start chain behaviour
	always @(negedge clk_sys)
	begin
		if (srst === 1'b0)
			`CHK(u_sac_link_if.convert_start_pin | u_sac_link_if.serial_in_pin, 1'b1)
	end

	// Let the enable edge settle before sampling the first wire bit
	always @(negedge u_sac_link_if.serial_out_oe_n)
	begin
		#1;
		first_bit = u_sac_link_if.serial_out_line;
		`CHK(reading, 1'b1)
	end

	task automatic xfer(input logic bsy, input logic four, input logic [DATA_W-1:0] val);
		int n;
		n = 0;
		while (host_busy !== 1'b0 && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
		sample_in = val;
		busy_sel = bsy;
		four_wire = four;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		repeat (40) @(negedge clk_sys);
		// Start pulse while busy must be ignored; input change must not leak in
		sample_in = ~val;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		`CHK(host_busy, 1'b1)
		`CHK(converting, 1'b1)
		n = 0;
		while (data_valid !== 1'b1 && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(data_out, val)
		`CHK(last_result, val)
		`CHK(first_bit, (bsy & ~four) ? 1'b0 : val[15])
		`CHK(cs_mode, 1'b1)
		`CHK(busy_option, bsy & ~four)
		`CHK(converting, 1'b0)
		// Converter sees the last clock fall or deselect some link cycles late
		repeat (12) @(negedge clk_sys);
		`CHK(u_sac_link_if.serial_out_line, 1'b1)
		`CHK(reading, 1'b0)
	endtask

	initial
	begin
		srst = 1'b1;
		link_rst = 1'b1;
		start = 1'b0;
		busy_sel = 1'b0;
		four_wire = 1'b0;
		sample_in = 16'h0000;
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		repeat (3) @(negedge link_clk);
		link_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		xfer(1'b0, 1'b0, 16'h8000);
		xfer(1'b1, 1'b0, 16'h7fff);
		xfer(1'b0, 1'b1, 16'ha5c3);
		xfer(1'b1, 1'b1, 16'h0001);
		xfer(1'b1, 1'b0, 16'hffff);
		repeat (200) @(negedge clk_sys);
		`CHK(vld_cnt, 5)
		`CHK(reading, 1'b0)
		conclude();
	end
endmodule // tb_top
